/* rtl/pbss_defines.svh */
// Constants of the pipelined burst synchronous memory.
// Assumes it is included by bare name from every file that needs a figure.
`ifndef PBSS_DEFINES_SVH
`define PBSS_DEFINES_SVH

// ****************************************
// Organisation
// ****************************************
`define PBSS_ADDR_W 21
`define PBSS_LANES 4
`define PBSS_LANE_W 9
`define PBSS_ADDR_W_X18 22
`define PBSS_ADDR_W_X72 20
`define PBSS_LANES_X18 2
`define PBSS_LANES_X72 8

// ****************************************
// Burst counter
// ****************************************
`define PBSS_BURST_W 2
`define PBSS_BURST_ZERO 2'h0
`define PBSS_BURST_STEP 2'h1

// ****************************************
// Pin input synchroniser
// ****************************************
`define PBSS_SYNC_STAGES 3

`endif

/* rtl/pbss_pkg.sv */
// Types shared by the memory core and its burst counter.
// Assumes pbss_defines.svh is on the include path.
`include "pbss_defines.svh"

package pbss_pkg;
    typedef enum logic [1:0] {
        PBSS_IDLE  = 2'b00,
        PBSS_READ  = 2'b01,
        PBSS_WRITE = 2'b11
    } pbss_access_t;

    typedef logic [`PBSS_BURST_W-1:0] pbss_burst_t;
endpackage

/* rtl/pbss_array_if.sv */
// Port bundle between the access pipeline and the storage array.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface pbss_array_if #(
    parameter int ADDR_W = 21,
    parameter int LANES = 4,
    parameter int LANE_W = 9
);
    logic [ADDR_W-1:0] addr;
    logic rdEn;
    logic [LANES-1:0] laneWe;
    logic [LANES*LANE_W-1:0] wrData;
    logic [LANES*LANE_W-1:0] rdData;

    modport core (output addr, output rdEn, output laneWe, output wrData, input rdData);
    modport store (input addr, input rdEn, input laneWe, input wrData, output rdData);
endinterface

`default_nettype wire

/* rtl/pbss_burst_ctr.sv */
// Two-bit burst counter with linear or interleaved ordering.
// Assumes load and advance come from registered inputs on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "pbss_defines.svh"

module pbss_burst_ctr
    import pbss_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic advance,
    input wire logic linearOrder,
    input wire pbss_pkg::pbss_burst_t seed,
    output pbss_pkg::pbss_burst_t offset
);
    pbss_burst_t seed_reg;
    pbss_burst_t count_reg;
    pbss_burst_t count_next;

    // ****************************************
    // Counter
    // ****************************************
    always_comb begin
        count_next = count_reg;
        if (load) begin
            count_next = `PBSS_BURST_ZERO;
        end else if (advance) begin
            count_next = count_reg + `PBSS_BURST_STEP;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= `PBSS_BURST_ZERO;
            seed_reg <= `PBSS_BURST_ZERO;
        end else begin
            count_reg <= count_next;
            if (load) begin
                seed_reg <= seed;
            end
        end
    end

    // Wrapping in two bits keeps the burst inside its aligned group of four.
    always_comb begin
        if (load) begin
            offset = seed;
        end else if (linearOrder) begin
            offset = seed_reg + count_next;
        end else begin
            offset = seed_reg ^ count_next;
        end
    end
endmodule

`default_nettype wire

/* rtl/pbss_array.sv */
// Storage array with per-lane write and one registered read stage.
// Assumes rdEn and laneWe are never both active for the same word.
`timescale 1ns/1ps
`default_nettype none

module pbss_array #(
    parameter int ADDR_W = 21,
    parameter int LANES = 4,
    parameter int LANE_W = 9
) (
    input wire logic clk,
    pbss_array_if.store port
);
    localparam int DEPTH = 1 << ADDR_W;

    logic [LANES*LANE_W-1:0] mem [DEPTH];
    logic [LANES*LANE_W-1:0] rdData_reg;

    // ****************************************
    // Byte lanes
    // ****************************************
    // The storage has no reset; contents are undefined until written.
    for (genvar lane = 0; lane < LANES; lane++) begin : gLane
        always_ff @(posedge clk) begin
            if (port.laneWe[lane]) begin
                mem[port.addr][lane*LANE_W +: LANE_W] <= port.wrData[lane*LANE_W +: LANE_W];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (port.rdEn) begin
            rdData_reg <= mem[port.addr];
        end
    end

    assign port.rdData = rdData_reg;
endmodule

`default_nettype wire

/* rtl/pbss_top.sv */
// Pipelined burst synchronous static memory, device side of the bus.
// Assumes a bus master on clk; output enable and sleep arrive from pins.
`timescale 1ns/1ps
`default_nettype none
`include "pbss_defines.svh"

module pbss_top
    import pbss_pkg::*;
#(
    parameter int ADDR_W = `PBSS_ADDR_W,
    parameter int LANES = `PBSS_LANES,
    parameter int LANE_W = `PBSS_LANE_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [LANES*LANE_W-1:0] writeData,
    input wire logic pipe_chip_sel_n,
    input wire logic depth_chip_sel_hi,
    input wire logic depth_chip_sel_lo_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic [LANES-1:0] lane_write_sel_n,
    input wire logic lane_write_qualify_n,
    input wire logic all_lanes_write_n,
    input wire logic burstOrderLinear,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    output logic [LANES*LANE_W-1:0] readData,
    output logic readDataOe
);
    import pbss_pkg::*;

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (!((ADDR_W == `PBSS_ADDR_W && LANES == `PBSS_LANES)
            || (ADDR_W == `PBSS_ADDR_W_X18 && LANES == `PBSS_LANES_X18)
            || (ADDR_W == `PBSS_ADDR_W_X72 && LANES == `PBSS_LANES_X72))) begin : gBadOrg
        $error("Unsupported array organisation");
    end
    if (LANE_W != `PBSS_LANE_W) begin : gBadLane
        $error("Lane width must be nine bits");
    end

    // ****************************************
    // Input registers
    // ****************************************
    logic [ADDR_W-1:0] addr_reg;
    logic [LANES*LANE_W-1:0] wrData_reg;
    logic sel1_reg;
    logic sel2_reg;
    logic sel3_reg;
    logic procStrobe_reg;
    logic ctrlStrobe_reg;
    logic advance_reg;
    logic [LANES-1:0] laneSel_reg;
    logic qualify_reg;
    logic allLanes_reg;
    logic linear_reg;

    // Strobes and write controls are held inactive through reset so no
    // access is started from whatever the pins show before the master wakes.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            procStrobe_reg <= 1'b0;
            ctrlStrobe_reg <= 1'b0;
            advance_reg <= 1'b0;
            laneSel_reg <= '0;
            qualify_reg <= 1'b0;
            allLanes_reg <= 1'b0;
        end else begin
            procStrobe_reg <= ~processor_addr_strobe_n;
            ctrlStrobe_reg <= ~controller_addr_strobe_n;
            advance_reg <= ~burst_advance_n;
            laneSel_reg <= ~lane_write_sel_n;
            qualify_reg <= ~lane_write_qualify_n;
            allLanes_reg <= ~all_lanes_write_n;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_reg <= '0;
            wrData_reg <= '0;
            sel1_reg <= 1'b0;
            sel2_reg <= 1'b0;
            sel3_reg <= 1'b0;
            linear_reg <= 1'b0;
        end else begin
            addr_reg <= addr;
            wrData_reg <= writeData;
            sel1_reg <= ~pipe_chip_sel_n;
            sel2_reg <= depth_chip_sel_hi;
            sel3_reg <= ~depth_chip_sel_lo_n;
            linear_reg <= burstOrderLinear;
        end
    end

    // ****************************************
    // Sleep synchroniser
    // ****************************************
    // The sleep pin blanks the drivers directly; this copy keeps new accesses
    // from starting and ends any burst in progress, so a few cycles of lag are harmless.
    logic [`PBSS_SYNC_STAGES-1:0] sleepSync_reg;
    logic sleeping_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sleepSync_reg <= '0;
        end else begin
            sleepSync_reg <= {sleepSync_reg[`PBSS_SYNC_STAGES-2:0], sleep_request};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sleeping_reg <= 1'b0;
        end else if (sleepSync_reg[1] == sleepSync_reg[2]) begin
            sleeping_reg <= sleepSync_reg[2];
        end
    end

    // ****************************************
    // Access decode
    // ****************************************
    logic selected;
    logic procStart;
    logic ctrlStart;
    logic start;
    logic deselect;
    logic writeReq;
    logic [LANES-1:0] laneWrite;
    logic active_reg;
    pbss_access_t access_reg;
    pbss_access_t access_next;
    logic [ADDR_W-`PBSS_BURST_W-1:0] upper_reg;
    pbss_burst_t burstOffset;
    logic [ADDR_W-1:0] accessAddr;

    assign selected = sel1_reg & sel2_reg & sel3_reg;
    // The processor strobe is ignored while the first select is inactive, so
    // a processor cycle aimed at another bank cannot close this one.
    assign procStart = procStrobe_reg & sel1_reg;
    assign ctrlStart = ctrlStrobe_reg;
    assign start = (procStart | ctrlStart) & ~sleeping_reg;
    assign deselect = start & ~selected;

    // Write width per lane: the global write overrides, else qualifier and
    // select must agree for each lane.
    always_comb begin
        laneWrite = '0;
        for (int lane = 0; lane < LANES; lane++) begin
            laneWrite[lane] = allLanes_reg | (qualify_reg & laneSel_reg[lane]);
        end
    end

    // A processor-strobe start is always a read; write controls that ride
    // with it are ignored, and a following cycle performs the write.
    assign writeReq = (|laneWrite) & ~procStart;

    always_comb begin
        access_next = PBSS_IDLE;
        if (start) begin
            if (!selected) begin
                access_next = PBSS_IDLE;
            end else if (writeReq) begin
                access_next = PBSS_WRITE;
            end else begin
                access_next = PBSS_READ;
            end
        end else if (active_reg && !sleeping_reg) begin
            if (writeReq) begin
                access_next = PBSS_WRITE;
            end else begin
                access_next = PBSS_READ;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            active_reg <= 1'b0;
        end else if (sleeping_reg || deselect) begin
            active_reg <= 1'b0;
        end else if (start) begin
            active_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            access_reg <= PBSS_IDLE;
        end else begin
            case (access_next)
                PBSS_READ: begin
                    access_reg <= PBSS_READ;
                end
                PBSS_WRITE: begin
                    access_reg <= PBSS_WRITE;
                end
                default: begin
                    access_reg <= PBSS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            upper_reg <= '0;
        end else if (start && selected) begin
            upper_reg <= addr_reg[ADDR_W-1:`PBSS_BURST_W];
        end
    end

    // ****************************************
    // Burst counter
    // ****************************************
    pbss_burst_ctr u_burst (
        .clk(clk),
        .rst_n(rst_n),
        .load(start & selected),
        .advance(~start & active_reg & advance_reg),
        .linearOrder(linear_reg),
        .seed(addr_reg[`PBSS_BURST_W-1:0]),
        .offset(burstOffset)
    );

    always_comb begin
        if (start) begin
            accessAddr = addr_reg;
        end else begin
            accessAddr = {upper_reg, burstOffset};
        end
    end

    // ****************************************
    // Array
    // ****************************************
    pbss_array_if #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) arrayBus ();

    assign arrayBus.addr = accessAddr;
    assign arrayBus.rdEn = (access_next == PBSS_READ);
    assign arrayBus.wrData = wrData_reg;
    assign arrayBus.laneWe = (access_next == PBSS_WRITE) ? laneWrite : '0;

    pbss_array #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) u_array (
        .clk(clk),
        .port(arrayBus)
    );

    // ****************************************
    // Output pipeline
    // ****************************************
    logic [LANES*LANE_W-1:0] dataOut_reg;
    logic outValid_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outValid_reg <= 1'b0;
        end else begin
            outValid_reg <= (access_reg == PBSS_READ);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dataOut_reg <= '0;
        end else if (access_reg == PBSS_READ) begin
            dataOut_reg <= arrayBus.rdData;
        end
    end

    assign readData = dataOut_reg;
    // Drivers follow the pins without a clock so the bus can be released
    // at once; the price is a glitch path from pin to driver enable.
    assign readDataOe = outValid_reg & ~output_enable_n & ~sleep_request;
endmodule

`default_nettype wire

/* dv/pbss_bus_master.sv */
// Bus master model that drives the synchronous pins of the memory.
// Assumes the bench calls its tasks; every change lands at a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "pbss_defines.svh"

module pbss_bus_master (
    input wire logic clk,
    output logic [`PBSS_ADDR_W-1:0] addr,
    output logic [`PBSS_LANES*`PBSS_LANE_W-1:0] writeData,
    output logic pipe_chip_sel_n,
    output logic depth_chip_sel_hi,
    output logic depth_chip_sel_lo_n,
    output logic processor_addr_strobe_n,
    output logic controller_addr_strobe_n,
    output logic burst_advance_n,
    output logic [`PBSS_LANES-1:0] lane_write_sel_n,
    output logic lane_write_qualify_n,
    output logic all_lanes_write_n
);
    // ****************************************
    // Pin drive
    // ****************************************
    task automatic set(input logic p, c, input logic [2:0] s, input logic n,
                       input logic [`PBSS_ADDR_W-1:0] a,
                       input logic [`PBSS_LANES*`PBSS_LANE_W-1:0] d,
                       input logic g, q, input logic [`PBSS_LANES-1:0] l);
        {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = {p, c, n};
        {pipe_chip_sel_n, depth_chip_sel_hi, depth_chip_sel_lo_n} = s;
        {addr, writeData} = {a, d};
        {all_lanes_write_n, lane_write_qualify_n, lane_write_sel_n} = {g, q, l};
    endtask

    task automatic put(input logic p, c, input logic [2:0] s, input logic n,
                       input logic [`PBSS_ADDR_W-1:0] a,
                       input logic [`PBSS_LANES*`PBSS_LANE_W-1:0] d,
                       input logic g, q, input logic [`PBSS_LANES-1:0] l);
        @(negedge clk);
        set(p, c, s, n, a, d, g, q, l);
    endtask

    // Idle is a deselect; released lines flip so a stale value never looks valid.
    task automatic idle();
        put(1'b1, 1'b0, 3'b000, 1'b1, ~addr, ~writeData, 1'b1, 1'b1, ~lane_write_sel_n);
    endtask

    initial begin
        set(1'b1, 1'b1, 3'b000, 1'b1, '0, '0, 1'b1, 1'b1, '1);
    end
endmodule

`default_nettype wire

/* dv/pbss_top_assertions.sv */
// Port-level checker for the memory top, attached by bind.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module pbss_checker #(
    parameter int ADDR_W = 21,
    parameter int LANES = 4,
    parameter int LANE_W = 9
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pipe_chip_sel_n,
    input wire logic depth_chip_sel_hi,
    input wire logic depth_chip_sel_lo_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic lane_write_qualify_n,
    input wire logic all_lanes_write_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic [LANES*LANE_W-1:0] readData,
    input wire logic readDataOe
);
    // ****************************************
    // Helpers
    // ****************************************
    // Sleep passes a synchroniser, so its age is counted before trusting it.
    logic [2:0] lowAge_reg;
    logic [2:0] highAge_reg;
    // Without a reset the ages would stay unknown and leave the read checks idle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lowAge_reg <= 3'h0;
            highAge_reg <= 3'h0;
        end else begin
            lowAge_reg <= sleep_request ? 3'h0 : (lowAge_reg == 3'h7 ? 3'h7 : lowAge_reg + 3'h1);
            highAge_reg <= !sleep_request ? 3'h0 : (highAge_reg == 3'h7 ? 3'h7 : highAge_reg + 3'h1);
        end
    end
    wire logic selOk = !pipe_chip_sel_n && depth_chip_sel_hi && !depth_chip_sel_lo_n;
    wire logic awake = !sleep_request && lowAge_reg >= 3'h5;
    wire logic noWrite = all_lanes_write_n && lane_write_qualify_n;
    wire logic gated = output_enable_n || sleep_request;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_ctrl_rd;
        !controller_addr_strobe_n && selOk && noWrite && awake;
    endsequence
    sequence s_proc_rd;
        !processor_addr_strobe_n && controller_addr_strobe_n && selOk && awake;
    endsequence
    sequence s_cont_rd;
        controller_addr_strobe_n && processor_addr_strobe_n && !burst_advance_n && noWrite;
    endsequence
    sequence s_desel;
        !controller_addr_strobe_n && !selOk;
    endsequence
    sequence s_no_start;
        (controller_addr_strobe_n || !selOk) && (processor_addr_strobe_n || pipe_chip_sel_n);
    endsequence

    // ****************************************
    // Properties
    // ****************************************
    property p_ctrl_read; s_ctrl_rd |-> ##3 (readDataOe || gated); endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("controller read gave no data");
    property p_proc_read; s_proc_rd |-> ##3 (readDataOe || gated); endproperty
    a_proc_read: assert property (p_proc_read) else $error("processor read gave no data");
    property p_burst; s_ctrl_rd ##1 s_cont_rd |-> ##3 (readDataOe || gated); endproperty
    a_burst: assert property (p_burst) else $error("second burst word missing");
    property p_deselect; s_desel ##1 s_no_start |-> ##2 !readDataOe; endproperty
    a_deselect: assert property (p_deselect) else $error("data after deselect");
    property p_write_silent;
        !controller_addr_strobe_n && selOk && !all_lanes_write_n |-> ##3 !readDataOe;
    endproperty
    a_write_silent: assert property (p_write_silent) else $error("write drove data");
    property p_oe_gate; output_enable_n |-> !readDataOe; endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("drivers on with enable high");
    property p_sleep_gate; sleep_request |-> !readDataOe; endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("drivers on in sleep");
    property p_sleep_refuse;
        highAge_reg >= 3'h6 && !controller_addr_strobe_n && selOk |-> ##3 !readDataOe;
    endproperty
    a_sleep_refuse: assert property (p_sleep_refuse) else $error("access taken in sleep");
    property p_data_stands; !$stable(readData) && !gated |-> readDataOe; endproperty
    a_data_stands: assert property (p_data_stands) else $error("data moved unflagged");
    property p_reset_clear; $rose(rst_n) |-> !readDataOe && readData == '0; endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("output not cleared");
endmodule

bind pbss_top pbss_checker #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) u_chk (
    .clk, .rst_n, .pipe_chip_sel_n, .depth_chip_sel_hi, .depth_chip_sel_lo_n,
    .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
    .lane_write_qualify_n, .all_lanes_write_n, .output_enable_n, .sleep_request,
    .readData, .readDataOe
);

`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the pipelined burst memory top.
// Assumes the default organisation of 21 address bits and four 9-bit lanes.
`timescale 1ns/1ps
`default_nettype none
`include "pbss_defines.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; $display("unexpected at %0t: got %h expected %h", $time, a, e); end end

module tb;
    typedef struct packed {logic gwN; logic bweN; logic [3:0] bwN; logic [35:0] expWord;} pbss_row_t;
    logic clk, rst_n, output_enable_n, sleep_request, burstOrderLinear, readDataOe;
    logic pipe_chip_sel_n, depth_chip_sel_hi, depth_chip_sel_lo_n, burst_advance_n;
    logic processor_addr_strobe_n, controller_addr_strobe_n, lane_write_qualify_n;
    logic all_lanes_write_n;
    logic [3:0] lane_write_sel_n;
    logic [20:0] addr, wa;
    logic [35:0] writeData, readData;
    logic [35:0] shadow [logic [20:0]];
    int comparisons = 0;
    int miscompares = 0;
    pbss_row_t rows [8] = '{'{1'b0, 1'b1, 4'hf, 36'hfffffffff}, '{1'b0, 1'b0, 4'he, 36'hfffffffff},
        '{1'b1, 1'b0, 4'he, 36'h0000001ff}, '{1'b1, 1'b0, 4'hd, 36'h00003fe00},
        '{1'b1, 1'b0, 4'hc, 36'h00003ffff}, '{1'b1, 1'b0, 4'h7, 36'hff8000000},
        '{1'b1, 1'b0, 4'h0, 36'hfffffffff}, '{1'b1, 1'b1, 4'h0, 36'h000000000}};
    logic [4:0] bad [4] = '{5'b10000, 5'b10011, 5'b10110, 5'b01110};

    pbss_bus_master m (.clk, .addr, .writeData, .pipe_chip_sel_n, .depth_chip_sel_hi,
        .depth_chip_sel_lo_n, .processor_addr_strobe_n, .controller_addr_strobe_n,
        .burst_advance_n, .lane_write_sel_n, .lane_write_qualify_n, .all_lanes_write_n);
    pbss_top u_dut (.clk, .rst_n, .addr, .writeData, .pipe_chip_sel_n, .depth_chip_sel_hi,
        .depth_chip_sel_lo_n, .processor_addr_strobe_n, .controller_addr_strobe_n,
        .burst_advance_n, .lane_write_sel_n, .lane_write_qualify_n, .all_lanes_write_n,
        .burstOrderLinear, .output_enable_n, .sleep_request, .readData, .readDataOe);

    // ****************************************
    // Tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [20:0] a, input logic [35:0] d, input logic g, q,
                      input logic [3:0] l);
        m.put(1'b1, 1'b0, 3'b010, 1'b1, a, d, g, q, l);
        m.idle();
    endtask

    // Returns at the falling edge where the first word stands; processor starts carry write controls.
    task automatic rd1(input logic [20:0] a, input logic p);
        m.put(~p, p, 3'b010, 1'b1, a, '0, ~p, ~p, 4'h0);
        m.idle();
        repeat (2) @(negedge clk);
    endtask

    task automatic rd(input logic [20:0] a, input int n, input logic lin);
        m.put(1'b1, 1'b0, 3'b010, 1'b1, a, '0, 1'b1, 1'b1, 4'hf);
        burstOrderLinear = lin;
        for (int j = 1; j <= n + 2; j++) begin
            if (j < n) m.put(1'b1, 1'b1, 3'b010, 1'b0, a, '0, 1'b1, 1'b1, 4'hf);
            else if (j == n) m.idle();
            else @(negedge clk);
            if (j == 2) `CHK(readDataOe, 1'b0)
            if (j >= 3) begin
                wa = {a[20:2], lin ? a[1:0] + 2'(j - 3) : a[1:0] ^ 2'(j - 3)};
                `CHK(readData, shadow[wa])
                `CHK(readDataOe, 1'b1)
            end
        end
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        {rst_n, output_enable_n, sleep_request, burstOrderLinear} = 4'h0;
        repeat (10) @(negedge clk);
        `CHK(readDataOe, 1'b0)
        `CHK(readData, 36'h0)
        rst_n = 1'b1;
        foreach (rows[r]) begin
            wr(21'h100 + 21'(r), 36'h0, 1'b0, 1'b1, 4'hf);
            wr(21'h100 + 21'(r), '1, rows[r].gwN, rows[r].bweN, rows[r].bwN);
            rd1(21'h100 + 21'(r), 1'b0);
            `CHK(readData, rows[r].expWord)
        end
        // A write burst steps without further strobes and wraps inside the group.
        burstOrderLinear = 1'b1;
        for (int k = 0; k < 4; k++) begin
            wa = {19'h80, 2'(1 + k)};
            shadow[wa] = 36'h0a0a0a0a0 + 36'(k);
            m.put(1'b1, k != 0, 3'b010, k == 0, 21'h201, shadow[wa], 1'b0, 1'b1, 4'hf);
        end
        m.idle();
        rd(21'h202, 4, 1'b1);
        rd(21'h203, 4, 1'b0);
        rd(21'h201, 4, 1'b0);
        shadow[21'h300] = 36'h5a5a5a5a5;
        wr(21'h300, shadow[21'h300], 1'b0, 1'b1, 4'hf);
        rd1(21'h300, 1'b1);
        `CHK(readData, shadow[21'h300])
        output_enable_n = 1'b1;
        #1 `CHK(readDataOe, 1'b0)
        output_enable_n = 1'b0;
        #1 `CHK(readDataOe, 1'b1)
        rd1(21'h300, 1'b0);
        `CHK(readData, shadow[21'h300])
        foreach (bad[i]) begin
            m.put(bad[i][4], bad[i][3], bad[i][2:0], 1'b1, 21'h300, '0, 1'b1, 1'b1, 4'hf);
            repeat (4) begin
                m.idle();
                `CHK(readDataOe, 1'b0)
            end
        end
        sleep_request = 1'b1;
        repeat (8) m.idle();
        m.put(1'b1, 1'b0, 3'b010, 1'b1, 21'h300, '0, 1'b1, 1'b1, 4'hf);
        sleep_request = 1'b0;
        repeat (4) begin
            m.idle();
            `CHK(readDataOe, 1'b0)
        end
        repeat (6) m.idle();
        rd1(21'h300, 1'b0);
        `CHK(readData, shadow[21'h300])
        tally_and_finish();
    end
endmodule

`default_nettype wire
